// File: hdl/switch_axis_defines.vh
// Purpose: constants for the switch and pulsar axis mode block
// Assumes: register word indexes chosen for this block
// Notes: one 32-bit word per register
`ifndef SWITCH_AXIS_DEFINES_VH
`define SWITCH_AXIS_DEFINES_VH
// Register addresses (word index on the plain port)
`define ADDR_ENV1 4'h0
`define ADDR_IRQ_EN 4'h1
`define ADDR_IRQ_CAUSE 4'h2
`define ADDR_EXT_STATUS 4'h3
`define ADDR_OP_SELECT 4'h4
`define ADDR_MOVE_AMOUNT 4'h5
`define ADDR_COMMAND 4'h6
`define ADDR_SPEED 4'h7
`define ADDR_PULSE_COUNT 4'h8
// Field positions
`define ENV1_SW_POL 25
`define ENV1_SW_FILT 27
`define IRQ_SW_CHANGE 17
`define CAUSE_FWD 17
`define CAUSE_REV 18
`define CAUSE_LIMIT_ERR 0
`define STS_FWD_LEVEL 11
`define STS_REV_LEVEL 12
// Operation select codes
`define OP_SW_CONT 7'h02
`define OP_SW_POS 7'h56
`define OP_PLS_LIN2 7'h6B
`define OP_PLS_CW 7'h6C
`define OP_PLS_CCW 7'h6D
// Commands
`define CMD_STOP_NOW 8'h49
`define CMD_START_LO 8'h50
`define CMD_START_HI_A 8'h52
`define CMD_START_HI_B 8'h53
// Run condition codes
`define CND_IDLE 4'h0
`define CND_WAIT_SW 4'h1
`define CND_RUN 4'h2
`define CND_DECEL 4'h3
// Timing: filter rejects pulses shorter than 32 ms at 20 MHz
`define FILTER_MS 32
`define CLK_KHZ 20000
`define FILTER_CYCLES (`FILTER_MS * `CLK_KHZ)
`define DECEL_STEPS 16'h0010
`endif

// File: hdl/switch_axis.v
// Purpose: per-axis switch driven and pulsar synchronised operating modes
// Assumes: inputs asynchronous, two-flop synchronised to REF_CLK at 20 MHz; speed profile reduced
// Notes: registers on a plain address/strobe port, read data one cycle later
//
// Operation
// - Pulsar steps interpolation; ignore pulses after completion
// - After start, switches produce output pulses
// - Polarity bit 25: 0 low, 1 high
// - Filter bit 27 rejects short switch pulses
// - Change interrupt enable bit 17 drives interrupt
// - Cause bit 17 forward, 18 reverse change
// - Waiting for switch reports condition 0001
// - Status bits 11, 12 show switch levels
// - Code 02h continuous, 56h positioning
// - Continuous moves only while a switch on
// - Continuous limit stop, no error, reverse allowed
// - Continuous persists until immediate stop command
// - High speed start decelerates when switch off
// - Opposite switch during decel: stop then reverse
// - Positioning start loads move amount
// - Positioning pulses count down, stop at zero
// - Positioning ignores later switch transitions
// - Zero move amount stops without pulses
// - Forward switch positive, reverse negative feed
// - Positioning limit stop raises error interrupt
//
// The implementer's own choices: strobed register access and the register offsets.
`include "switch_axis_defines.vh"
`default_nettype none
module switch_axis (
    input wire REF_CLK, // 20 MHz clock
    input wire RESET, // async reset, active high
    input wire [3:0] ADDR, // register word index
    input wire [31:0] WDATA, // write data
    input wire WR, // write strobe
    input wire RD, // read strobe
    output reg [31:0] RDATA, // read data, cycle after RD
    input wire FWD_SWITCH_IN, // forward direction switch
    input wire REV_SWITCH_IN, // reverse direction switch
    input wire MANUAL_INPUT_ENABLE_N, // switch input enable, active low
    input wire FWD_END_LIMIT_IN, // forward end limit, active high
    input wire REV_END_LIMIT_IN, // reverse end limit, active high
    input wire PULSAR_IN, // manual pulse generator step
    output reg PULSE_OUT, // command pulse
    output reg DIR_OUT, // 1 = negative feed
    output wire INT_N // interrupt, active low
);
    // ************************************************************
    // Registers and state
    // ************************************************************
    localparam ST_IDLE = 3'h0;
    localparam ST_WAIT = 3'h1;
    localparam ST_RUN = 3'h2;
    localparam ST_DECEL = 3'h3;
    localparam ST_INTERP = 3'h4;

    // Written by software; irq_cause is set by events and cleared by reading
    reg [31:0] env1;
    reg [31:0] irq_en;
    reg [31:0] irq_cause;
    reg [6:0] op_select;
    reg [27:0] move_amount;
    reg [15:0] speed_div;

    // Motion state
    reg [27:0] pos_count;
    reg [31:0] pulse_count;
    reg [2:0] state;
    reg high_speed;
    reg run_dir;
    reg [15:0] decel_cnt;
    reg [15:0] rate_cnt;
    reg [3:0] run_condition_field;
    reg limit_err;

    // Input conditioning
    reg [5:0] s1;
    reg [5:0] s2;
    reg [5:0] s3;
    wire [2:0] filt;
    reg prev_fwd;
    reg prev_rev;

    // ************************************************************
    // Input decode
    // ************************************************************
    wire pol = env1[`ENV1_SW_POL];
    // Raw levels after synchroniser, turned to "on" by polarity
    wire fwd_raw = pol ? s2[0] : ~s2[0];
    wire rev_raw = pol ? s2[1] : ~s2[1];
    wire en_raw = ~s2[2];
    wire [2:0] raw = {en_raw, rev_raw, fwd_raw};
    wire [2:0] lvl = env1[`ENV1_SW_FILT] ? filt : raw;
    // Enable gates motion only; status and change events follow the switch
    wire fwd_on = lvl[0] & lvl[2];
    wire rev_on = lvl[1] & lvl[2];
    wire lim_fwd = s2[3];
    wire lim_rev = s2[4];
    wire pulsar_step = s2[5] & ~s3[5];
    // Only the limit ahead of the feed blocks motion
    wire lim_hit = run_dir ? lim_rev : lim_fwd;
    wire tick = (rate_cnt == 16'h0000);

    // ************************************************************
    // Command and operation decode
    // ************************************************************
    wire cmd = WR && (ADDR == `ADDR_COMMAND);
    wire stop_cmd = cmd && (WDATA[7:0] == `CMD_STOP_NOW);
    wire start_cmd = cmd && (WDATA[7:0] >= `CMD_START_LO) && (WDATA[7:0] <= `CMD_START_HI_B);
    wire start_hi = (WDATA[7:0] == `CMD_START_HI_A) || (WDATA[7:0] == `CMD_START_HI_B);
    wire op_cont = (op_select == `OP_SW_CONT);
    wire op_pos = (op_select == `OP_SW_POS);
    wire op_pulsar = (op_select == `OP_PLS_LIN2) || (op_select == `OP_PLS_CW) ||
                     (op_select == `OP_PLS_CCW);
    wire fwd_chg = lvl[0] ^ prev_fwd;
    wire rev_chg = lvl[1] ^ prev_rev;

    // ************************************************************
    // Input synchroniser and filter
    // ************************************************************
    always @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            // Switch and enable pins start at their idle high level, so no false change
            s1 <= 6'h07;
            s2 <= 6'h07;
            s3 <= 6'h07;
        end else begin
            s1 <= {PULSAR_IN, REV_END_LIMIT_IN, FWD_END_LIMIT_IN,
                   MANUAL_INPUT_ENABLE_N, REV_SWITCH_IN, FWD_SWITCH_IN};
            s2 <= s1;
            s3 <= s2;
        end
    end

    // One filter per input: forward, reverse and enable
    level_filter #(.WINDOW(`FILTER_CYCLES)) level_filter_fwd_inst (
        .clk(REF_CLK),
        .rst(RESET),
        .raw(raw[0]),
        .level(filt[0])
    );

    level_filter #(.WINDOW(`FILTER_CYCLES)) level_filter_rev_inst (
        .clk(REF_CLK),
        .rst(RESET),
        .raw(raw[1]),
        .level(filt[1])
    );

    level_filter #(.WINDOW(`FILTER_CYCLES)) level_filter_en_inst (
        .clk(REF_CLK),
        .rst(RESET),
        .raw(raw[2]),
        .level(filt[2])
    );

    // ************************************************************
    // Operation control
    // ************************************************************
    always @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            state <= ST_IDLE;
            high_speed <= 1'b0;
            run_dir <= 1'b0;
            pos_count <= 28'h0000000;
            decel_cnt <= 16'h0000;
            rate_cnt <= 16'h0000;
            PULSE_OUT <= 1'b0;
            DIR_OUT <= 1'b0;
            pulse_count <= 32'h00000000;
            limit_err <= 1'b0;
        end else begin
            PULSE_OUT <= 1'b0;
            limit_err <= 1'b0;
            rate_cnt <= tick ? speed_div : rate_cnt - 16'h0001;
            if (stop_cmd) begin
                state <= ST_IDLE;
            end else if (start_cmd) begin
                high_speed <= start_hi;
                pos_count <= move_amount;
                rate_cnt <= speed_div;
                if (op_cont) begin
                    state <= ST_WAIT;
                end else if (op_pos) begin
                    state <= (move_amount == 28'h0000000) ? ST_IDLE : ST_WAIT;
                end else if (op_pulsar) begin
                    state <= (move_amount == 28'h0000000) ? ST_IDLE : ST_INTERP;
                end
            end else begin
                case (state)
                    ST_WAIT: begin
                        if (fwd_on || rev_on) begin
                            run_dir <= ~fwd_on;
                            DIR_OUT <= ~fwd_on;
                            state <= ST_RUN;
                        end
                    end
                    ST_RUN: begin
                        if (op_pos) begin
                            // Switch levels no longer looked at here
                            if (lim_hit) begin
                                limit_err <= 1'b1;
                                state <= ST_IDLE;
                            end else if (tick) begin
                                PULSE_OUT <= 1'b1;
                                pulse_count <= pulse_count + 32'h00000001;
                                pos_count <= pos_count - 28'h0000001;
                                if (pos_count == 28'h0000001)
                                    state <= ST_IDLE;
                            end
                        end else begin
                            if (!(run_dir ? rev_on : fwd_on)) begin
                                if (high_speed) begin
                                    decel_cnt <= `DECEL_STEPS;
                                    state <= ST_DECEL;
                                end else begin
                                    state <= ST_WAIT;
                                end
                            end else if (lim_hit) begin
                                state <= ST_RUN;
                            end else if (tick) begin
                                PULSE_OUT <= 1'b1;
                                pulse_count <= pulse_count + 32'h00000001;
                            end
                        end
                    end
                    ST_DECEL: begin
                        // Slowing: pulse on every second tick until the ramp ends
                        if (decel_cnt == 16'h0000 || lim_hit) begin
                            state <= ST_WAIT;
                        end else if (tick) begin
                            decel_cnt <= decel_cnt - 16'h0001;
                            PULSE_OUT <= decel_cnt[0];
                            if (decel_cnt[0])
                                pulse_count <= pulse_count + 32'h00000001;
                        end
                    end
                    ST_INTERP: begin
                        if (pulsar_step) begin
                            PULSE_OUT <= 1'b1;
                            pulse_count <= pulse_count + 32'h00000001;
                            pos_count <= pos_count - 28'h0000001;
                            if (pos_count == 28'h0000001)
                                state <= ST_IDLE;
                        end
                    end
                    default: state <= state;
                endcase
            end
        end
    end

    // ************************************************************
    // Run condition
    // ************************************************************
    always @* begin
        case (state)
            ST_WAIT: run_condition_field = `CND_WAIT_SW;
            ST_RUN: run_condition_field = `CND_RUN;
            ST_DECEL: run_condition_field = `CND_DECEL;
            ST_INTERP: run_condition_field = `CND_RUN;
            default: run_condition_field = `CND_IDLE;
        endcase
    end

    // ************************************************************
    // Configuration registers
    // ************************************************************
    always @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            env1 <= 32'h00000000;
            irq_en <= 32'h00000000;
            op_select <= 7'h00;
            move_amount <= 28'h0000000;
            speed_div <= 16'h0000;
        end else if (WR) begin
            case (ADDR)
                `ADDR_ENV1: env1 <= WDATA;
                `ADDR_IRQ_EN: irq_en <= WDATA;
                `ADDR_OP_SELECT: op_select <= WDATA[6:0];
                `ADDR_MOVE_AMOUNT: move_amount <= WDATA[27:0];
                `ADDR_SPEED: speed_div <= WDATA[15:0];
                default: op_select <= op_select;
            endcase
        end
    end

    // ************************************************************
    // Switch change events and interrupt
    // ************************************************************
    // Levels delayed by one cycle for change detection
    always @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            prev_fwd <= 1'b0;
            prev_rev <= 1'b0;
        end else begin
            prev_fwd <= lvl[0];
            prev_rev <= lvl[1];
        end
    end

    // Cause reads clear; a new event in the same cycle survives
    always @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            irq_cause <= 32'h00000000;
        end else begin
            if (RD && ADDR == `ADDR_IRQ_CAUSE)
                irq_cause <= 32'h00000000;
            if (fwd_chg && irq_en[`IRQ_SW_CHANGE])
                irq_cause[`CAUSE_FWD] <= 1'b1;
            if (rev_chg && irq_en[`IRQ_SW_CHANGE])
                irq_cause[`CAUSE_REV] <= 1'b1;
            if (limit_err)
                irq_cause[`CAUSE_LIMIT_ERR] <= 1'b1;
        end
    end

    assign INT_N = ~(|irq_cause);

    // ************************************************************
    // Read data
    // ************************************************************
    // Read data stand for one cycle only and are zero otherwise
    always @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            RDATA <= 32'h00000000;
        end else if (RD) begin
            case (ADDR)
                `ADDR_IRQ_CAUSE: RDATA <= irq_cause;
                `ADDR_EXT_STATUS: RDATA <= {19'h00000, lvl[1], lvl[0], 7'h00, run_condition_field};
                `ADDR_OP_SELECT: RDATA <= {25'h0000000, op_select};
                `ADDR_MOVE_AMOUNT: RDATA <= {4'h0, pos_count};
                `ADDR_PULSE_COUNT: RDATA <= pulse_count;
                default: RDATA <= 32'h00000000;
            endcase
        end else begin
            RDATA <= 32'h00000000;
        end
    end
endmodule

// ************************************************************
// Level filter
// ************************************************************
// A new level passes only after standing for the whole window
module level_filter #(
    parameter WINDOW = `FILTER_CYCLES
) (
    input wire clk, // clock
    input wire rst, // async reset, active high
    input wire raw, // level before filtering
    output reg level // filtered level
);
    reg [24:0] count;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            level <= 1'b0;
            count <= 25'h0000000;
        end else if (raw == level) begin
            count <= 25'h0000000;
        end else if (count == WINDOW - 1) begin
            level <= raw;
            count <= 25'h0000000;
        end else begin
            count <= count + 25'h0000001;
        end
    end
endmodule
`default_nettype wire

// File: testbench/axis_far_side.sv
// Purpose: far side model, direction switches and motor driver
// Assumes: bench chooses the switch polarity
// Notes: pulses counted per feed direction, never cleared
`default_nettype none
module axis_far_side (
    input wire logic clk, // clock
    input wire logic active_high, // switch polarity
    input wire logic fwd_on, // forward switch pressed
    input wire logic rev_on, // reverse switch pressed
    output logic fwd_pin, // forward switch pin
    output logic rev_pin, // reverse switch pin
    input wire logic pulse, // command pulse
    input wire logic dir_neg, // negative feed
    output int pos_cnt, // positive pulses
    output int neg_cnt // negative pulses
);
    timeunit 1ns;
    timeprecision 1ns;
    assign fwd_pin = active_high ? fwd_on : !fwd_on;
    assign rev_pin = active_high ? rev_on : !rev_on;
    initial begin
        pos_cnt = 0;
        neg_cnt = 0;
    end
    always @(posedge clk) begin
        if (pulse && dir_neg) neg_cnt <= neg_cnt + 1;
        if (pulse && !dir_neg) pos_cnt <= pos_cnt + 1;
    end
endmodule
`default_nettype wire

// File: testbench/switch_axis_asserts.sv
// Purpose: port checker for the switch axis block
// Assumes: switch filter left off, speed divider at least 1
// Notes: limit checks allow for the two-flop synchroniser
`include "switch_axis_defines.vh"
`default_nettype none
module switch_axis_asserts (
    input wire logic REF_CLK, // clock
    input wire logic RESET, // reset
    input wire logic [3:0] ADDR, // address
    input wire logic RD, // read strobe
    input wire logic [31:0] RDATA, // read data
    input wire logic FWD_END_LIMIT_IN, // forward limit
    input wire logic REV_END_LIMIT_IN, // reverse limit
    input wire logic PULSE_OUT, // command pulse
    input wire logic DIR_OUT, // direction
    input wire logic INT_N // interrupt
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RESET);
    sequence s_fwd_block;
        FWD_END_LIMIT_IN [*6];
    endsequence
    sequence s_rev_block;
        REV_END_LIMIT_IN [*6];
    endsequence
    a_rdata_idle: assert property (!$past(RD) |-> RDATA == 32'h0)
        else $error("read data not zero outside read answer");
    a_rdata_unmapped: assert property (RD && ADDR > 4'h8 |=> RDATA == 32'h0)
        else $error("unmapped read not zero");
    a_int_release: assert property ($rose(INT_N) |-> $past(RD && ADDR == `ADDR_IRQ_CAUSE))
        else $error("interrupt released without cause read");
    a_int_hold: assert property (!INT_N && !(RD && ADDR == `ADDR_IRQ_CAUSE) |=> !INT_N)
        else $error("interrupt dropped without cause read");
    a_pulse_single: assert property (PULSE_OUT |=> !PULSE_OUT)
        else $error("command pulse longer than one cycle");
    a_fwd_limit: assert property (s_fwd_block |-> !(PULSE_OUT && !DIR_OUT))
        else $error("forward pulse into active limit");
    a_rev_limit: assert property (s_rev_block |-> !(PULSE_OUT && DIR_OUT))
        else $error("reverse pulse into active limit");
    a_reset_out: assert property ($fell(RESET) |-> INT_N && !PULSE_OUT && !DIR_OUT)
        else $error("outputs not at reset values");
endmodule
`default_nettype wire

// File: testbench/tb_switch_axis.sv
// Purpose: self-checking bench for the switch axis block
// Assumes: switch filter off, speed divider 3
// Notes: pulse totals come from the far side model
`include "switch_axis_defines.vh"
`default_nettype none
module tb_switch_axis;
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************
    // Bench
    // ****************************************
    logic ref_clk, reset, wr, rd, enable_n, fwd_limit, rev_limit, pulsar;
    logic pulse, dir_neg, int_n, active_high, fwd_on, rev_on, fwd_pin, rev_pin;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, d;
    int pos_cnt, neg_cnt, base, num_errors, n_compared;
    logic [4:0] rows [0:7] = '{5'h00, 5'h05, 5'h0A, 5'h0F, 5'h10, 5'h15, 5'h1A, 5'h1F};
    switch_axis switch_axis_inst (.REF_CLK(ref_clk), .RESET(reset), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .FWD_SWITCH_IN(fwd_pin),
        .REV_SWITCH_IN(rev_pin), .MANUAL_INPUT_ENABLE_N(enable_n),
        .FWD_END_LIMIT_IN(fwd_limit), .REV_END_LIMIT_IN(rev_limit), .PULSAR_IN(pulsar),
        .PULSE_OUT(pulse), .DIR_OUT(dir_neg), .INT_N(int_n));
    axis_far_side axis_far_side_inst (.clk(ref_clk), .active_high(active_high),
        .fwd_on(fwd_on), .rev_on(rev_on), .fwd_pin(fwd_pin), .rev_pin(rev_pin),
        .pulse(pulse), .dir_neg(dir_neg), .pos_cnt(pos_cnt), .neg_cnt(neg_cnt));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (num_errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        addr <= a;
        wdata <= v;
        wr <= 1'h1;
        @(posedge ref_clk);
        wr <= 1'h0;
    endtask
    task automatic rd_reg(input logic [3:0] a);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge ref_clk);
        rd <= 1'h0;
        #1 d = rdata;
    endtask
    task automatic sw(input logic f, input logic r);
        @(posedge ref_clk);
        fwd_on <= f;
        rev_on <= r;
    endtask
    task automatic start(input logic [6:0] op, input logic [31:0] mv, input logic [7:0] c);
        wr_reg(`ADDR_OP_SELECT, {25'h0, op});
        wr_reg(`ADDR_MOVE_AMOUNT, mv);
        wr_reg(`ADDR_COMMAND, {24'h0, c});
        cyc(4);
    endtask
    task automatic run_condition_field(input logic [3:0] exp);
        rd_reg(`ADDR_EXT_STATUS);
        check(d[3:0], exp);
    endtask
    initial begin
        ref_clk = 1'h0;
        forever #25 ref_clk = ~ref_clk;
    end
    initial begin
        #400000;
        num_errors++;
        summarize();
    end
    initial begin
        {reset, wr, rd, fwd_limit, rev_limit, pulsar, active_high, fwd_on, rev_on} = 9'h100;
        {addr, wdata, enable_n} = 37'h0;
        cyc(2);
        reset <= 1'h0;
        run_condition_field(`CND_IDLE);
        check(int_n, 1'h1);
        rd_reg(4'hF);
        check(d, 32'h0);
        for (int i = 0; i < 8; i++) begin
            wr_reg(`ADDR_ENV1, {6'h00, rows[i][4], 25'h0000000});
            active_high <= rows[i][4];
            {fwd_on, rev_on} <= rows[i][3:2];
            cyc(6);
            rd_reg(`ADDR_EXT_STATUS);
            check(d[12:11], {rows[i][0], rows[i][1]});
        end
        sw(1'h0, 1'h0);
        cyc(4);
        wr_reg(`ADDR_IRQ_EN, 32'h00020000);
        wr_reg(`ADDR_SPEED, 32'h00000003);
        start(`OP_SW_CONT, 32'h0, `CMD_START_LO);
        run_condition_field(`CND_WAIT_SW);
        base = pos_cnt;
        enable_n <= 1'h1;
        sw(1'h1, 1'h0);
        cyc(10);
        run_condition_field(`CND_WAIT_SW);
        check(pos_cnt, base);
        enable_n <= 1'h0;
        cyc(40);
        check(int_n, 1'h0);
        rd_reg(`ADDR_IRQ_CAUSE);
        check(d[18:17], 2'h1);
        check(int_n, 1'h1);
        check(pos_cnt > base + 4, 1'h1);
        sw(1'h0, 1'h1);
        cyc(10);
        base = neg_cnt;
        cyc(30);
        check(neg_cnt > base + 4, 1'h1);
        rd_reg(`ADDR_IRQ_CAUSE);
        check(d[18:17], 2'h3);
        @(posedge ref_clk);
        rev_limit <= 1'h1;
        cyc(10);
        base = neg_cnt;
        cyc(20);
        check(neg_cnt, base);
        rd_reg(`ADDR_IRQ_CAUSE);
        check(d[0], 1'h0);
        base = pos_cnt;
        sw(1'h1, 1'h0);
        cyc(40);
        check(pos_cnt > base + 4, 1'h1);
        rev_limit <= 1'h0;
        wr_reg(`ADDR_COMMAND, {24'h0, `CMD_STOP_NOW});
        cyc(4);
        run_condition_field(`CND_IDLE);
        base = pos_cnt;
        cyc(20);
        check(pos_cnt, base);
        sw(1'h0, 1'h0);
        start(`OP_SW_CONT, 32'h0, `CMD_START_HI_A);
        sw(1'h1, 1'h0);
        cyc(40);
        sw(1'h0, 1'h0);
        cyc(8);
        run_condition_field(`CND_DECEL);
        base = neg_cnt;
        sw(1'h0, 1'h1);
        cyc(300);
        check(neg_cnt > base, 1'h1);
        wr_reg(`ADDR_COMMAND, {24'h0, `CMD_STOP_NOW});
        sw(1'h0, 1'h0);
        start(`OP_SW_POS, 32'h5, `CMD_START_LO);
        base = pos_cnt;
        sw(1'h1, 1'h0);
        cyc(8);
        sw(1'h0, 1'h0);
        cyc(60);
        check(pos_cnt - base, 5);
        run_condition_field(`CND_IDLE);
        start(`OP_SW_POS, 32'h0, `CMD_START_LO);
        run_condition_field(`CND_IDLE);
        base = pos_cnt;
        sw(1'h1, 1'h0);
        cyc(20);
        check(pos_cnt, base);
        sw(1'h0, 1'h0);
        start(`OP_SW_POS, 32'h100, `CMD_START_LO);
        sw(1'h0, 1'h1);
        cyc(20);
        rev_limit <= 1'h1;
        cyc(10);
        run_condition_field(`CND_IDLE);
        check(int_n, 1'h0);
        rd_reg(`ADDR_IRQ_CAUSE);
        check(d[0], 1'h1);
        rev_limit <= 1'h0;
        sw(1'h0, 1'h0);
        start(`OP_PLS_LIN2, 32'h3, `CMD_START_LO);
        base = pos_cnt + neg_cnt;
        repeat (5) begin
            pulsar <= 1'h1;
            cyc(4);
            pulsar <= 1'h0;
            cyc(4);
        end
        check(pos_cnt + neg_cnt - base, 3);
        rd_reg(`ADDR_MOVE_AMOUNT);
        check(d, 32'h0);
        rd_reg(`ADDR_OP_SELECT);
        check(d, {25'h0, `OP_PLS_LIN2});
        rd_reg(`ADDR_PULSE_COUNT);
        check(d, pos_cnt + neg_cnt);
        reset <= 1'h1;
        cyc(2);
        check({int_n, pulse, dir_neg}, 3'h4);
        reset <= 1'h0;
        cyc(2);
        run_condition_field(`CND_IDLE);
        summarize();
    end
endmodule
bind switch_axis switch_axis_asserts switch_axis_asserts_inst (.REF_CLK, .RESET, .ADDR, .RD,
    .RDATA, .FWD_END_LIMIT_IN, .REV_END_LIMIT_IN, .PULSE_OUT, .DIR_OUT, .INT_N);
`default_nettype wire
